//--- rtl/pulse_switch_pkg.sv
// Purpose: Constants for the pulse-count switch controller
// Assumes: 100 MHz system clock
// Notes:   Times are held in their own unit; cycle counts derive from them
package pulse_switch_pkg;
  localparam int CLOCK_MHZ            = 100;
  localparam int LATCH_TIMEOUT_US     = 500;
  localparam int OFF_TIMEOUT_US       = 500;
  localparam int TURN_ON_MAX_NS       = 2700;
  localparam int MIN_HIGH_PHASE_NS    = 50;
  localparam int MAX_HIGH_PHASE_US    = 75;
  localparam int LOW_PHASE_MIN_NS     = 500;
  localparam int LOW_PHASE_MAX_US     = 75;
  // Nanosecond times round down to whole cycles
  localparam int LATCH_TIMEOUT_CYCLES = LATCH_TIMEOUT_US * CLOCK_MHZ;
  localparam int OFF_TIMEOUT_CYCLES   = OFF_TIMEOUT_US * CLOCK_MHZ;
  localparam int TURN_ON_MAX_CYCLES   = (TURN_ON_MAX_NS * CLOCK_MHZ) / 1000;
  localparam int TIMER_WIDTH          = 16;
  localparam int CHANNELS_MAX         = 6;
  localparam int THREE_CH_BITS        = 3;
  localparam logic [CHANNELS_MAX-1:0] ALL_ON  = 6'h3F;
  localparam logic [CHANNELS_MAX-1:0] ALL_OFF = 6'h00;
  localparam logic [CHANNELS_MAX-1:0] COUNT_CLEAR = 6'h00;
  localparam logic [TIMER_WIDTH-1:0]  TIMER_CLEAR = 16'h0000;
endpackage

//--- rtl/level_timer.sv
// Purpose: Counts how long a level has stood and flags the timeout
// Assumes: Restart pulse marks every start of the watched level
// Notes:   Saturates after expiry, so the flag pulses once per level
`timescale 1ns/1ps
module level_timer
  import pulse_switch_pkg::*;
#(
  parameter logic [TIMER_WIDTH-1:0] LIMIT = 16'h0001
) (
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic restart_in,
  input  wire logic active_in,
  output logic      expired_out
);
  logic [TIMER_WIDTH-1:0] count_reg;

  always_ff @(posedge clock_in) begin
    if (!resetn_in || restart_in || !active_in) begin
      count_reg <= TIMER_CLEAR;
    end else if (count_reg != LIMIT) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= active_in && !restart_in && (count_reg == LIMIT - 16'h0001);
    end
  end
endmodule

//--- rtl/pulse_count_switch_control.sv
// Purpose: Decodes a single-wire pulse-count line into low-side switch states
// Assumes: Control line is asynchronous and synchronised here
// Notes:   Six-channel build by default; three-channel build wraps the count at eight
`timescale 1ns/1ps
module pulse_count_switch_control
  import pulse_switch_pkg::*;
#(
  parameter int                     SIX_CHANNELS   = 1,
  parameter logic [TIMER_WIDTH-1:0] LATCH_CYCLES   = TIMER_WIDTH'(LATCH_TIMEOUT_CYCLES),
  parameter logic [TIMER_WIDTH-1:0] OFF_CYCLES     = TIMER_WIDTH'(OFF_TIMEOUT_CYCLES)
) (
  input  wire logic                    clock_in,
  input  wire logic                    resetn_in,
  input  wire logic                    pulse_line_in,
  output logic [CHANNELS_MAX-1:0]      ground_enable_out,
  output logic                         enabled_out
);
  import pulse_switch_pkg::*;

  typedef enum logic [1:0] {SHUTDOWN, COUNTING, HOLDING} mode_e;

  logic                    line_meta_reg;
  logic                    line_sync_reg;
  logic                    line_prev_reg;
  logic                    rise;
  logic                    fall;
  logic                    latch_expired;
  logic                    off_expired;
  logic [CHANNELS_MAX-1:0] edge_count_reg;
  logic [CHANNELS_MAX-1:0] edge_count_next;
  mode_e                   mode_reg;

  // Edge count minus one, set bits mark channels that are off
  function automatic logic [CHANNELS_MAX-1:0] decode_count(input logic [CHANNELS_MAX-1:0] count, input int six);
    logic [CHANNELS_MAX-1:0] offs;
    offs = count - 6'h01;
    if (six == 0) begin
      offs = {3'h7, offs[THREE_CH_BITS-1:0]};
    end
    return ~offs;
  endfunction

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      line_meta_reg <= 1'b0;
      line_sync_reg <= 1'b0;
      line_prev_reg <= 1'b0;
    end else begin
      line_meta_reg <= pulse_line_in;
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  assign rise = line_sync_reg && !line_prev_reg;
  assign fall = !line_sync_reg && line_prev_reg;

  level_timer #(.LIMIT(LATCH_CYCLES)) latch_timer (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .restart_in  (rise),
    .active_in   (line_sync_reg),
    .expired_out (latch_expired)
  );

  level_timer #(.LIMIT(OFF_CYCLES)) off_timer (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .restart_in  (fall),
    .active_in   (!line_sync_reg),
    .expired_out (off_expired)
  );

  // Three channels wrap after eight edges; six wrap through zero, which decodes as edge 64
  always_comb begin
    edge_count_next = edge_count_reg + 6'h01;
    if (SIX_CHANNELS == 0 && edge_count_reg == 6'h08) begin
      edge_count_next = 6'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      edge_count_reg <= COUNT_CLEAR;
    end else if (off_expired) begin
      // A rise that meets the off timeout starts a new series rather than being lost
      edge_count_reg <= rise ? 6'h01 : COUNT_CLEAR;
    end else if (rise) begin
      edge_count_reg <= edge_count_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mode_reg <= SHUTDOWN;
    end else begin
      case (mode_reg)
        SHUTDOWN: begin
          if (rise) begin
            mode_reg <= COUNTING;
          end
        end
        COUNTING: begin
          if (off_expired && !rise) begin
            mode_reg <= SHUTDOWN;
          end else if (latch_expired) begin
            mode_reg <= HOLDING;
          end
        end
        default: begin
          if (off_expired && !rise) begin
            mode_reg <= SHUTDOWN;
          end else if (rise) begin
            mode_reg <= COUNTING;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ground_enable_out <= ALL_OFF;
      enabled_out       <= 1'b0;
    end else if (rise && (mode_reg == SHUTDOWN || off_expired)) begin
      ground_enable_out <= SIX_CHANNELS != 0 ? ALL_ON : 6'h07;
      enabled_out       <= 1'b1;
    end else if (off_expired) begin
      ground_enable_out <= ALL_OFF;
      enabled_out       <= 1'b0;
    end else if (latch_expired && mode_reg == COUNTING) begin
      ground_enable_out <= decode_count(edge_count_reg, SIX_CHANNELS);
      enabled_out       <= 1'b1;
    end
  end

  // Latch applies to the outputs one cycle after the timeout flag
  latch_apply_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (latch_expired && mode_reg == COUNTING && !off_expired) |=>
      ground_enable_out == decode_count($past(edge_count_reg), SIX_CHANNELS))
    else $error("latched state not applied");

  shutdown_open_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (off_expired && !rise) |=> ground_enable_out == ALL_OFF && !enabled_out && edge_count_reg == COUNT_CLEAR)
    else $error("shutdown did not open switches");

  first_edge_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (mode_reg == SHUTDOWN && rise) |=> enabled_out && ground_enable_out[2:0] == 3'h7)
    else $error("first edge did not enable all");

  sequence hold_high_s;
    line_sync_reg [*2];
  endsequence

  count_step_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (rise && !off_expired && edge_count_reg != 6'h08) |=> edge_count_reg == $past(edge_count_reg) + 6'h01)
    else $error("edge not counted");

  short_low_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (!latch_expired && !off_expired && !(mode_reg == SHUTDOWN && rise)) |=> $stable(ground_enable_out))
    else $error("outputs changed without latch");

  latch_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hold_high_s ##0 latch_expired) |-> mode_reg == COUNTING || mode_reg == HOLDING)
    else $error("latch outside a series");

  wrap_three_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (SIX_CHANNELS == 0 && rise && edge_count_reg == 6'h08 && !off_expired) |=> edge_count_reg == 6'h01)
    else $error("three channel count did not wrap");

  off_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (mode_reg == SHUTDOWN) |-> !enabled_out && ground_enable_out == ALL_OFF)
    else $error("enabled while shut down");

  count_clear_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (mode_reg == SHUTDOWN) |-> edge_count_reg == COUNT_CLEAR)
    else $error("count kept through shutdown");

  enter_shutdown_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (off_expired && !rise) |=> mode_reg == SHUTDOWN)
    else $error("off timeout did not shut down");

  off_low_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    off_expired |-> !$past(line_sync_reg))
    else $error("off timeout while line high");

  latch_high_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    latch_expired |-> $past(line_sync_reg))
    else $error("latch timeout while line low");

  upper_off_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (SIX_CHANNELS == 0) |-> ground_enable_out[5:3] == 3'h0)
    else $error("absent channel switched on");

  on_enabled_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (ground_enable_out != ALL_OFF) |-> enabled_out)
    else $error("switch on while disabled");

  hold_keep_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (mode_reg == HOLDING && !rise && !off_expired) |=> mode_reg == HOLDING)
    else $error("held state left without an edge");

  sequence first_rise_s;
    (mode_reg == SHUTDOWN) ##0 rise;
  endsequence

  first_count_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    first_rise_s |=> mode_reg == COUNTING && edge_count_reg == 6'h01)
    else $error("first edge did not open a series");
endmodule

//--- test/pulse_host_model.sv
// Purpose: Host GPIO that sends a pulse series on the control line
// Assumes: Phases are counted in system clock cycles
// Notes:   A count of zero parks the line low
`timescale 1ns/1ps
module pulse_host_model #(
  parameter int HIGH_CYCLES = 50,
  parameter int LOW_CYCLES  = 50
) (
  input  wire logic       clock_in,
  input  wire logic [6:0] count_in,
  input  wire logic       start_in,
  output logic            line_out,
  output logic            busy_out
);
  initial begin
    line_out = 1'b0;
    busy_out = 1'b0;
  end
  always begin
    @(posedge clock_in);
    if (start_in) begin
      busy_out <= 1'b1;
      if (line_out) begin
        line_out <= 1'b0;
        repeat (LOW_CYCLES) @(posedge clock_in);
      end
      for (int i = 0; i < count_in; i++) begin
        line_out <= 1'b1;
        if (i == count_in - 1) break;
        repeat (HIGH_CYCLES) @(posedge clock_in);
        line_out <= 1'b0;
        repeat (LOW_CYCLES) @(posedge clock_in);
      end
      // Busy drops one edge later so it is never assigned twice in one step
      @(posedge clock_in);
      busy_out <= 1'b0;
    end
  end
endmodule

//--- test/pulse_count_switch_control_tb.sv
// Purpose: Self-checking bench for both channel builds on one line
// Assumes: Timeouts shortened to 200 cycles
// Notes:   Expected states come from the count-minus-one decoding
`timescale 1ns/1ps
module pulse_count_switch_control_tb;
  import pulse_switch_pkg::*;
  localparam logic [TIMER_WIDTH-1:0] TMO = 16'h00C8;
  localparam int                     T   = 200;
  localparam int                     PH  = 50;
  logic                    clock_in    = 1'b0;
  logic                    resetn_in   = 1'b0;
  logic [6:0]              count_reg   = 7'h00;
  logic                    start_reg   = 1'b0;
  logic                    line;
  logic                    busy;
  logic [CHANNELS_MAX-1:0] ground6;
  logic [CHANNELS_MAX-1:0] ground3;
  logic                    en6;
  logic                    en3;
  int                      mismatches  = 0;
  int                      checks_done = 0;
  int                      prev        = 1;
  always #5 clock_in = ~clock_in;
  pulse_host_model #(.HIGH_CYCLES(PH), .LOW_CYCLES(PH)) i_host (
    .clock_in(clock_in), .count_in(count_reg), .start_in(start_reg), .line_out(line), .busy_out(busy));
  pulse_count_switch_control #(.SIX_CHANNELS(1), .LATCH_CYCLES(TMO), .OFF_CYCLES(TMO)) i_dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .pulse_line_in(line), .ground_enable_out(ground6),
    .enabled_out(en6));
  pulse_count_switch_control #(.SIX_CHANNELS(0), .LATCH_CYCLES(TMO), .OFF_CYCLES(TMO)) i_dut_three (
    .clock_in(clock_in), .resetn_in(resetn_in), .pulse_line_in(line), .ground_enable_out(ground3),
    .enabled_out(en3));
  function automatic logic [6:0] want(input int n, input bit six);
    if (n == 0) return 7'h00;
    return six ? {1'b1, ~6'((n - 1) % 64)} : {4'h8, ~3'((n - 1) % 8)};
  endfunction
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic look(input string what, input int cycles, input int n);
    repeat (cycles) @(negedge clock_in);
    check({what, " six"}, {en6, ground6}, want(n, 1'b1));
    check({what, " three"}, {en3, ground3}, want(n, 1'b0));
  endtask
  task automatic send(input int n);
    @(posedge clock_in);
    count_reg <= 7'(n);
    start_reg <= 1'b1;
    @(posedge clock_in);
    start_reg <= 1'b0;
    #1;
    for (int k = 0; k < 9000 && busy !== 1'b0; k++) @(negedge clock_in);
  endtask
  task automatic shutdown(input int n);
    send(0);
    // The host has already held the line low for PH cycles when send returns
    look("before off", T - PH - 20, n);
    look("after off", 40, 0);
  endtask
  task automatic first_pulse();
    shutdown(0);
    send(1);
    look("first rise", 6, 1);
    look("single latched", T + TURN_ON_MAX_CYCLES, 1);
  endtask
  task automatic decode(input int n);
    shutdown(prev);
    send(n);
    look("before latch", T - 10, 1);
    look("decoded", 10 + TURN_ON_MAX_CYCLES, n);
    prev = n;
  endtask
  task automatic accumulate();
    send(3);
    look("held", T - 10, prev);
    look("accumulated", 10 + TURN_ON_MAX_CYCLES, prev + 3);
  endtask
  task automatic results();
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock_in);
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    look("after reset", 2, 0);
    first_pulse();
    decode(2);
    decode(5);
    decode(9);
    decode(33);
    decode(64);
    decode(65);
    accumulate();
    results();
  end
endmodule
